//--- bpa_pkg.sv
// package: constants and carrier types for the shared-bus arbiter glue
package bpa_pkg;
    // ======
    // shared bus and buffer ram
    localparam int          BUS_W          = 16;
    localparam int          RAM_AW         = 12;
    localparam logic [15:0] FLAG_OFFSET    = 16'hff00;
    // ======
    // control/status register high byte bit positions
    localparam int          FLAG_B15       = 15;
    localparam int          FLAG_B14       = 14;
    localparam int          FLAG_B13       = 13;
    localparam int          FLAG_B12       = 12;
    localparam int          FLAG_B11       = 11;
    localparam int          FLAG_B10       = 10;
    localparam int          FLAG_B9        = 9;
    localparam int          FLAG_B8        = 8;
    localparam logic [7:0]  FLAG_HI_RST    = 8'h00;
    // ======
    // processor address map
    localparam int          CPU_AW         = 24;
    localparam int          ADDR_BP_BIT    = 23;
    localparam logic [23:0] ROM_TOP        = 24'h01ffff;
    localparam logic [23:0] RAM_BASE       = 24'h020000;
    localparam logic [23:0] RAM_TOP        = 24'h020fff;
    localparam logic [23:0] MODEM_BASE     = 24'h040000;
    localparam logic [23:0] MODEM_TOP      = 24'h04ffff;
    localparam logic [23:0] GIO_BASE       = 24'h050000;
    localparam logic [23:0] GIO_TOP        = 24'h05ffff;
    // ======
    // interrupt levels
    localparam logic [2:0]  LVL_SERIAL     = 3'h6;
    localparam logic [2:0]  LVL_IFACE      = 3'h3;
    localparam logic [2:0]  LVL_DMA        = 3'h2;
    localparam logic [2:0]  LVL_TIMER      = 3'h1;
    localparam logic [2:0]  LVL_NONE       = 3'h0;
    localparam logic [2:0]  FC_INTACK      = 3'h7;
    // ======
    // types
    typedef enum logic [1:0]
    {
        BPA_IFACE = 2'b00,
        BPA_CPU   = 2'b01,
        BPA_DMA   = 2'b11
    } bpa_owner_e;

    typedef struct packed
    {
        logic rom;
        logic ram;
        logic modem;
        logic gio;
    } bpa_local_sel_s;
endpackage : bpa_pkg

//--- bpa_int_enc.sv
// interrupt priority encoder and acknowledge steering
`timescale 1ns/1ns
`default_nettype none
module bpa_int_enc
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    // sources
    input  wire logic        serial_int_i,
    input  wire logic        iface_int_i,
    input  wire logic        dma_int_i,
    input  wire logic        timer_int_i,
    // processor side
    input  wire logic [2:0]  cpu_function_code_i,
    input  wire logic [3:1]  cpu_addr_lo_i,
    input  wire logic        valid_mem_addr_i,
    output logic      [2:0]  cpu_int_level_o,
    output logic             cpu_int_ack_o,
    output logic             serial_int_ack_o,
    output logic             autovector_req_o,
    output logic             iface_int_ack_o,
    output logic             dma_int_ack_o,
    output logic             timer_int_ack_o
);
    logic ack;
    // ======
    // level encoder, highest source wins
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cpu_int_level_o <= 3'h0;
        else if (serial_int_i)
            cpu_int_level_o <= bpa_pkg::LVL_SERIAL;
        else if (iface_int_i)
            cpu_int_level_o <= bpa_pkg::LVL_IFACE;
        else if (dma_int_i)
            cpu_int_level_o <= bpa_pkg::LVL_DMA;
        else if (timer_int_i)
            cpu_int_level_o <= bpa_pkg::LVL_TIMER;
        else
            cpu_int_level_o <= bpa_pkg::LVL_NONE;
    end

    assign ack = (cpu_function_code_i == bpa_pkg::FC_INTACK);
    // ======
    // acknowledge split: vectored for serial, autovector otherwise
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cpu_int_ack_o    <= 1'b0;
            serial_int_ack_o <= 1'b0;
            autovector_req_o <= 1'b0;
            iface_int_ack_o  <= 1'b0;
            dma_int_ack_o    <= 1'b0;
            timer_int_ack_o  <= 1'b0;
        end
        else
        begin
            cpu_int_ack_o    <= ack;
            serial_int_ack_o <= ack && cpu_addr_lo_i[3];
            autovector_req_o <= ack && !cpu_addr_lo_i[3];
            // decoder only enabled by the valid strobe during autovector
            iface_int_ack_o  <= ack && valid_mem_addr_i && cpu_addr_lo_i == bpa_pkg::LVL_IFACE;
            dma_int_ack_o    <= ack && valid_mem_addr_i && cpu_addr_lo_i == bpa_pkg::LVL_DMA;
            timer_int_ack_o  <= ack && valid_mem_addr_i && cpu_addr_lo_i == bpa_pkg::LVL_TIMER;
        end
    end
endmodule : bpa_int_enc
`default_nettype wire

//--- bpa_addr_dec.sv
// processor address decoder: local half versus shared bus half
`timescale 1ns/1ns
`default_nettype none
module bpa_addr_dec
(
    // processor cycle
    input  wire logic [23:0]            cpu_addr_i,
    input  wire logic                   cpu_strobe_i,
    // decoded
    output logic                        bp_hit_o,
    output bpa_pkg::bpa_local_sel_s     local_sel_o
);
    function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction : in_rng

    // ======
    // bit 23 alone splits the space; local decoder only when clear
    always_comb
    begin
        bp_hit_o          = cpu_strobe_i && cpu_addr_i[bpa_pkg::ADDR_BP_BIT];
        local_sel_o       = '0;
        if (cpu_strobe_i && !cpu_addr_i[bpa_pkg::ADDR_BP_BIT])
        begin
            local_sel_o.rom   = in_rng(cpu_addr_i, 24'h000000, bpa_pkg::ROM_TOP);
            local_sel_o.ram   = in_rng(cpu_addr_i, bpa_pkg::RAM_BASE, bpa_pkg::RAM_TOP);
            local_sel_o.modem = in_rng(cpu_addr_i, bpa_pkg::MODEM_BASE, bpa_pkg::MODEM_TOP);
            local_sel_o.gio   = in_rng(cpu_addr_i, bpa_pkg::GIO_BASE, bpa_pkg::GIO_TOP);
        end
    end
endmodule : bpa_addr_dec
`default_nettype wire

//--- bpa_glue.sv
// top: shared-bus arbiter, buffer ram strobes, control/status high byte
// Operation
// - grant processor or dma on request; interface chip granted by default
// - sequencer drives buffer ram enables and strobes for every owner
// - shared bus is sixteen bits, address and data multiplexed
// - 4k-word ram on word address 12:1, held in per-agent latches
// - low byte lives in ram; high byte in dedicated logic
// - bits 14,10,8 read direct; 15,13,12 real to processor, zero to host
// - bit 11 always reads zero
// - interface write with bit 9 set latches programmed reset
// - bit 15 with that write latches skip-self-test
// - processor or interface write to ff00 strobes high byte; only interface writes strobe both reset latches
// - register read drives a dedicated output enable onto the bus
// - processor 0-7fffff local, 800000-ffffff shared bus
// - bit 23 raises shared bus request and latches the ram word address
// - bit 23 clear enables local rom, ram, modem, io decoding
// - rom region decodes up to 01ffff
// - priority encode serial 6, interface 3, dma 2, timer 1
// - function code all ones gives interrupt acknowledge; level on addr 3:1
// - acknowledge with bit 3 set gives serial acknowledge via shared bus
// - acknowledge with bit 3 clear asserts autovector request
// - valid memory strobe enables acknowledge decoder for autovector sources
// - rom and local ram reachable by processor only
// - interface grant held except while another agent owns bus
`timescale 1ns/1ns
`default_nettype none
module bpa_glue
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    // processor
    input  wire logic [23:0] cpu_addr_i,
    input  wire logic        cpu_strobe_i,
    input  wire logic        cpu_write_i,
    input  wire logic [15:0] cpu_data_i,
    input  wire logic [2:0]  cpu_function_code_i,
    input  wire logic        valid_mem_addr_i,
    output logic             cpu_grant_o,
    output logic [2:0]       cpu_int_level_o,
    output logic             cpu_int_ack_o,
    output logic             serial_int_ack_o,
    output logic             autovector_req_o,
    output logic             rom_sel_o,
    output logic             ram_sel_o,
    output logic             modem_sel_o,
    output logic             gio_sel_o,
    // interface chip
    input  wire logic        iface_mem_req_i,
    input  wire logic        iface_read_dir_i,
    input  wire logic [11:0] iface_ram_addr_i,
    output logic             iface_bus_grant_o,
    output logic             iface_mem_ack_o,
    output logic             iface_int_ack_o,
    // dma controller
    input  wire logic        dma_hold_req_i,
    input  wire logic        dma_write_i,
    input  wire logic [11:0] dma_ram_addr_i,
    output logic             dma_grant_o,
    output logic             dma_int_ack_o,
    // interrupt sources
    input  wire logic        serial_int_i,
    input  wire logic        iface_int_i,
    input  wire logic        dma_int_i,
    input  wire logic        timer_int_i,
    output logic             timer_int_ack_o,
    // shared bus, flag address decode and buffer ram
    input  wire logic [15:0] bus_dal_i,
    output logic [15:0]      bus_dal_o,
    output logic             bus_dal_oe_n_o,
    output logic [11:0]      ram_addr_o,
    output logic             ram_cs_o,
    output logic             ram_we_o,
    output logic             ram_oe_o,
    // reset latches
    output logic             programmed_reset_o,
    output logic             skip_self_test_o
);
    // ======
    // signal declarations
    bpa_pkg::bpa_owner_e     owner_reg;
    logic                    bp_hit;
    bpa_pkg::bpa_local_sel_s lsel;
    logic                    cpu_req;
    logic                    cpu_req_reg;
    logic [11:0]             cpu_addr_lat_reg;
    logic [11:0]             dma_addr_lat_reg;
    logic [11:0]             iface_addr_lat_reg;
    logic                    iface_strobe_reg;
    logic                    serial_ack_w;
    logic                    access_done;
    logic                    cur_write;
    logic [11:0]             cur_addr;
    logic                    flag_hit;
    logic                    flag_wr;
    logic                    flag_rd;
    logic [7:0]              flag_hi_reg;
    logic                    flag_sel_reg;
    logic                    iface_data_ph;

    // ======
    // address decode and interrupt logic
    bpa_addr_dec u_dec
    (
        .cpu_addr_i   (cpu_addr_i),
        .cpu_strobe_i (cpu_strobe_i),
        .bp_hit_o     (bp_hit),
        .local_sel_o  (lsel)
    );

    bpa_int_enc u_int
    (
        .ref_clk_i           (ref_clk_i),
        .arst_n_i            (arst_n_i),
        .serial_int_i        (serial_int_i),
        .iface_int_i         (iface_int_i),
        .dma_int_i           (dma_int_i),
        .timer_int_i         (timer_int_i),
        .cpu_function_code_i (cpu_function_code_i),
        .cpu_addr_lo_i       (cpu_addr_i[3:1]),
        .valid_mem_addr_i    (valid_mem_addr_i),
        .cpu_int_level_o     (cpu_int_level_o),
        .cpu_int_ack_o       (cpu_int_ack_o),
        .serial_int_ack_o    (serial_ack_w),
        .autovector_req_o    (autovector_req_o),
        .iface_int_ack_o     (iface_int_ack_o),
        .dma_int_ack_o       (dma_int_ack_o),
        .timer_int_ack_o     (timer_int_ack_o)
    );
    assign serial_int_ack_o = serial_ack_w;

    // serial acknowledge also wants the shared bus to read its vector
    assign cpu_req = bp_hit || serial_ack_w;

    // ======
    // local selects registered; rom and ram never reachable from the host side
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rom_sel_o   <= 1'b0;
            ram_sel_o   <= 1'b0;
            modem_sel_o <= 1'b0;
            gio_sel_o   <= 1'b0;
        end
        else
        begin
            rom_sel_o   <= lsel.rom;
            ram_sel_o   <= lsel.ram;
            modem_sel_o <= lsel.modem;
            gio_sel_o   <= lsel.gio;
        end
    end

    // ======
    // per-agent word address latches; bit 0 dropped, words only
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cpu_addr_lat_reg <= 12'h000;
        else if (cpu_req && !cpu_req_reg)
            cpu_addr_lat_reg <= cpu_addr_i[12:1];
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            dma_addr_lat_reg <= 12'h000;
        else if (owner_reg == bpa_pkg::BPA_DMA)
            dma_addr_lat_reg <= dma_ram_addr_i;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            iface_addr_lat_reg <= 12'h000;
        else if (iface_mem_req_i && !iface_strobe_reg)
            iface_addr_lat_reg <= iface_ram_addr_i;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cpu_req_reg <= 1'b0;
        else
            cpu_req_reg <= cpu_req;
    end

    // ======
    // arbiter: owner stays until its request drops, interface until its strobe drops; dma beats processor
    always_comb
    begin
        case (owner_reg)
            bpa_pkg::BPA_CPU: access_done = !cpu_req;
            bpa_pkg::BPA_DMA: access_done = !dma_hold_req_i;
            default:          access_done = !iface_strobe_reg;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            owner_reg <= bpa_pkg::BPA_IFACE;
        else if (access_done)
        begin
            if (dma_hold_req_i)
                owner_reg <= bpa_pkg::BPA_DMA;
            else if (cpu_req)
                owner_reg <= bpa_pkg::BPA_CPU;
            else
                owner_reg <= bpa_pkg::BPA_IFACE;
        end
    end

    // ======
    // grants registered from current owner and access_done so outputs stay clean
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cpu_grant_o       <= 1'b0;
            dma_grant_o       <= 1'b0;
            iface_bus_grant_o <= 1'b1;
        end
        else
        begin
            cpu_grant_o       <= (owner_reg == bpa_pkg::BPA_CPU) && !access_done;
            dma_grant_o       <= (owner_reg == bpa_pkg::BPA_DMA) && !access_done;
            iface_bus_grant_o <= (owner_reg == bpa_pkg::BPA_IFACE) || access_done;
        end
    end

    // interface acknowledge then strobe, each one cycle later
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            iface_mem_ack_o  <= 1'b0;
            iface_strobe_reg <= 1'b0;
            flag_sel_reg     <= 1'b0;
        end
        else
        begin
            iface_mem_ack_o  <= iface_mem_req_i && owner_reg == bpa_pkg::BPA_IFACE;
            iface_strobe_reg <= iface_mem_ack_o;
            // address phase is the edge on which the acknowledge rises
            flag_sel_reg     <= (iface_mem_req_i && !iface_mem_ack_o) ? (bus_dal_i == bpa_pkg::FLAG_OFFSET) : flag_sel_reg;
        end
    end

    // ======
    // current access attributes by owner
    always_comb
    begin
        case (owner_reg)
            bpa_pkg::BPA_CPU:
            begin
                cur_write = cpu_write_i;
                cur_addr  = cpu_addr_lat_reg;
            end
            bpa_pkg::BPA_DMA:
            begin
                cur_write = dma_write_i;
                cur_addr  = dma_addr_lat_reg;
            end
            default:
            begin
                cur_write = !iface_read_dir_i;
                cur_addr  = iface_addr_lat_reg;
            end
        endcase
    end

    // host data follows its ff00 address one cycle later, so the hit is remembered
    assign flag_hit = cpu_addr_i[15:0] == bpa_pkg::FLAG_OFFSET;
    assign iface_data_ph = (owner_reg == bpa_pkg::BPA_IFACE) && flag_sel_reg && iface_mem_ack_o && !iface_strobe_reg;
    assign flag_wr = (owner_reg == bpa_pkg::BPA_CPU) ? cpu_grant_o && flag_hit && cpu_write_i
                     : iface_data_ph && !iface_read_dir_i;
    assign flag_rd = (owner_reg == bpa_pkg::BPA_CPU) ? cpu_grant_o && flag_hit && !cpu_write_i
                     : iface_data_ph && iface_read_dir_i;

    // ======
    // buffer ram strobes from the sequencer for any owner
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ram_addr_o <= 12'h000;
            ram_cs_o   <= 1'b0;
            ram_we_o   <= 1'b0;
            ram_oe_o   <= 1'b0;
        end
        else
        begin
            ram_addr_o <= cur_addr;
            ram_cs_o   <= (owner_reg != bpa_pkg::BPA_IFACE || iface_strobe_reg) && !access_done;
            // low byte is the device type in ram; writes are always whole words
            ram_we_o   <= cur_write && (owner_reg != bpa_pkg::BPA_IFACE || iface_strobe_reg) && !access_done;
            ram_oe_o   <= !cur_write && (owner_reg != bpa_pkg::BPA_IFACE || iface_strobe_reg) && !access_done;
        end
    end

    // ======
    // high byte of control/status, clocked by the flag write strobe
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            flag_hi_reg <= bpa_pkg::FLAG_HI_RST;
        else if (flag_wr)
        begin
            flag_hi_reg    <= cpu_data_sel(owner_reg, cpu_data_i, bus_dal_i);
            flag_hi_reg[1] <= 1'b0; // bit 9 bypasses the register logic
            flag_hi_reg[3] <= 1'b0;
        end
    end

    function automatic logic [7:0] cpu_data_sel(input bpa_pkg::bpa_owner_e o, input logic [15:0] c,
                                                input logic [15:0] b);
        cpu_data_sel = (o == bpa_pkg::BPA_CPU) ? c[15:8] : b[15:8];
    endfunction : cpu_data_sel

    // ======
    // reset latches: only an interface write with read direction negated
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            programmed_reset_o <= 1'b0;
            skip_self_test_o   <= 1'b0;
        end
        else if (flag_wr && owner_reg == bpa_pkg::BPA_IFACE && !iface_read_dir_i)
        begin
            programmed_reset_o <= bus_dal_i[bpa_pkg::FLAG_B9];
            skip_self_test_o   <= bus_dal_i[bpa_pkg::FLAG_B9] && bus_dal_i[bpa_pkg::FLAG_B15];
        end
    end

    // ======
    // read-back: processor sees all, host sees zero in 15,13,12
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            bus_dal_o      <= 16'h0000;
            bus_dal_oe_n_o <= 1'b1;
        end
        else
        begin
            bus_dal_oe_n_o <= !flag_rd;
            bus_dal_o      <= 16'h0000;
            if (flag_rd)
            begin
                bus_dal_o[bpa_pkg::FLAG_B14] <= flag_hi_reg[6];
                bus_dal_o[bpa_pkg::FLAG_B10] <= flag_hi_reg[2];
                bus_dal_o[bpa_pkg::FLAG_B8]  <= flag_hi_reg[0];
                bus_dal_o[bpa_pkg::FLAG_B9]  <= programmed_reset_o;
                if (owner_reg == bpa_pkg::BPA_CPU)
                begin
                    bus_dal_o[bpa_pkg::FLAG_B15] <= flag_hi_reg[7];
                    bus_dal_o[bpa_pkg::FLAG_B13] <= flag_hi_reg[5];
                    bus_dal_o[bpa_pkg::FLAG_B12] <= flag_hi_reg[4];
                end
                bus_dal_o[bpa_pkg::FLAG_B11] <= 1'b0;
            end
        end
    end
endmodule : bpa_glue
`default_nettype wire

//--- bpa_glue_monitor.sv
// port-level assertions for the arbiter glue
`timescale 1ns/1ns
`default_nettype none
module bpa_glue_monitor
(
    // clock, reset and causes
    input wire logic ref_clk_i, arst_n_i, cpu_strobe_i, dma_hold_req_i,
    input wire logic serial_int_i, iface_int_i, dma_int_i, timer_int_i,
    input wire logic [23:0] cpu_addr_i,
    input wire logic [2:0] cpu_function_code_i, cpu_int_level_o,
    // glue outputs
    input wire logic cpu_grant_o, dma_grant_o, iface_bus_grant_o, rom_sel_o,
    input wire logic cpu_int_ack_o, serial_int_ack_o, autovector_req_o
);
    logic [2:0] lvl_exp;
    // highest pending source sets the level
    assign lvl_exp = serial_int_i ? 3'h6 : iface_int_i ? 3'h3 : dma_int_i ? 3'h2 : {2'h0, timer_int_i};
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    // ======
    // arbiter
    a_single_grant: assert property (!(cpu_grant_o && dma_grant_o))
        else $error("two grants");
    a_iface_default: assert property (iface_bus_grant_o == !(cpu_grant_o || dma_grant_o))
        else $error("iface grant wrong");
    a_dma_held: assert property (dma_grant_o && dma_hold_req_i |=> dma_grant_o)
        else $error("dma grant dropped");
    a_dma_answer: assert property ($rose(dma_hold_req_i) && iface_bus_grant_o |-> ##[1:3] dma_grant_o)
        else $error("dma not granted");
    // ======
    // interrupts and decode
    a_int_level: assert property (1'b1 |=> cpu_int_level_o == $past(lvl_exp))
        else $error("bad level");
    a_auto_vector: assert property (cpu_function_code_i == 3'h7 && !cpu_addr_i[3] |=> autovector_req_o && cpu_int_ack_o)
        else $error("no autovector");
    a_serial_ack: assert property (cpu_function_code_i == 3'h7 && cpu_addr_i[3] |=> serial_int_ack_o && !autovector_req_o)
        else $error("no serial ack");
    a_rom_select: assert property (cpu_strobe_i && cpu_addr_i <= 24'h01ffff |=> rom_sel_o)
        else $error("rom not selected");
endmodule : bpa_glue_monitor
bind bpa_glue bpa_glue_monitor u_mon (.*);
`default_nettype wire

//--- bpa_dma_model.sv
// dma controller stand-in: hold request, address only behind the grant
`timescale 1ns/1ns
`default_nettype none
module bpa_dma_model
(
    // clock, reset and bench control
    input wire logic ref_clk_i, arst_n_i, start_i,
    input wire logic [2:0] beats_i,
    // glue side
    input wire logic dma_grant_i,
    output logic dma_hold_req_o,
    output logic [11:0] dma_ram_addr_o
);
    logic [2:0] beat_reg;
    // hold stays up for beats_i + 1 granted cycles, so both quick and slow owners occur
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
        if (!arst_n_i)
            {dma_hold_req_o, beat_reg} <= '0;
        else if (!dma_hold_req_o)
            {dma_hold_req_o, beat_reg} <= {start_i, 3'h0};
        else if (dma_grant_i)
            {dma_hold_req_o, beat_reg} <= {beat_reg != beats_i, beat_reg + 3'h1};
    // released lines toggle rather than keep a stale address
    assign dma_ram_addr_o = dma_grant_i ? 12'h5a5 : {12{ref_clk_i}};
endmodule : bpa_dma_model
`default_nettype wire

//--- bpa_testbench.sv
// self-checking bench for the arbiter glue
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic ref_clk_i, arst_n_i, cpu_strobe_i, cpu_write_i, valid_mem_addr_i, iface_mem_req_i, iface_read_dir_i;
    logic dma_hold_req_i, dma_write_i, serial_int_i, iface_int_i, dma_int_i, timer_int_i, cpu_grant_o, dma_go;
    logic cpu_int_ack_o, serial_int_ack_o, autovector_req_o, rom_sel_o, ram_sel_o, modem_sel_o, gio_sel_o;
    logic iface_bus_grant_o, iface_mem_ack_o, iface_int_ack_o, dma_grant_o, dma_int_ack_o, timer_int_ack_o;
    logic bus_dal_oe_n_o, ram_cs_o, ram_we_o, ram_oe_o, programmed_reset_o, skip_self_test_o;
    logic [2:0] cpu_function_code_i, cpu_int_level_o, dma_beats;
    logic [11:0] iface_ram_addr_i, dma_ram_addr_i, ram_addr_o;
    logic [15:0] cpu_data_i, bus_dal_i, bus_dal_o;
    logic [23:0] cpu_addr_i;
    logic [2:0] lv [4] = '{3'h6, 3'h3, 3'h2, 3'h1};
    logic [23:0] da [4] = '{24'h01ffff, 24'h020000, 24'h040000, 24'h050000};
    int mismatches, num_checks;
    always #50 ref_clk_i = ~ref_clk_i;
    bpa_glue u_dut (.*);
    bpa_dma_model u_dma (.ref_clk_i, .arst_n_i, .start_i(dma_go), .beats_i(dma_beats), .dma_grant_i(dma_grant_o),
        .dma_hold_req_o(dma_hold_req_i), .dma_ram_addr_o(dma_ram_addr_i));
    // inputs move 5 ns after the edge so nothing races the sampling edge
    task automatic tk(input int n);
        repeat (n) @(posedge ref_clk_i);
        #5;
    endtask : tk
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        mismatches += int'(s !== e);
        if (s !== e) $display("Error %s expected %h seen %h", n, e, s);
    endtask : chk
    // bounded wait: a lost handshake is reported instead of hanging
    task automatic wt(ref logic s, input logic v, input string n);
        for (int i = 0; i < 40 && s !== v; i++) tk(1);
        chk(n, 16'(s), 16'(v));
    endtask : wt
    task automatic cpu(input logic [23:0] a, input logic w, input logic [15:0] d, input logic [7:0] e);
        {cpu_addr_i, cpu_write_i, cpu_data_i, cpu_strobe_i} = {a, w, d, 1'b1};
        wt(cpu_grant_o, 1'b1, "cpu grant");
        if (!w) wt(bus_dal_oe_n_o, 1'b0, "flag oe");
        if (!w) chk("cpu flag", 16'(bus_dal_o[15:8]), 16'(e));
        cpu_strobe_i = 1'b0;
        wt(cpu_grant_o, 1'b0, "cpu release");
    endtask : cpu
    // host side: flag address until acknowledged, then data
    task automatic ifc(input logic rd, input logic [15:0] d, input logic [7:0] e);
        {iface_read_dir_i, iface_ram_addr_i, bus_dal_i, iface_mem_req_i} = {rd, 12'hf80, 16'hff00, 1'b1};
        wt(iface_mem_ack_o, 1'b1, "iface ack");
        bus_dal_i = d;
        if (rd) wt(bus_dal_oe_n_o, 1'b0, "flag oe");
        if (rd) chk("iface flag", 16'(bus_dal_o[15:8]), 16'(e));
        iface_mem_req_i = 1'b0;
        wt(iface_mem_ack_o, 1'b0, "iface done");
        tk(2);
    endtask : ifc
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // the tests need some 100 cycles; 2000 leaves ample margin
    initial
    begin
        #200000;
        mismatches++;
        print_verdict();
    end
    initial
    begin
        {ref_clk_i, arst_n_i, cpu_strobe_i, cpu_write_i, valid_mem_addr_i, iface_mem_req_i, dma_go} = '0;
        {iface_read_dir_i, dma_write_i, serial_int_i, iface_int_i, dma_int_i, timer_int_i} = '0;
        {cpu_function_code_i, cpu_addr_i, cpu_data_i, bus_dal_i, iface_ram_addr_i, dma_beats} = '0;
        tk(12);
        arst_n_i = 1'b1;
        tk(1);
        chk("reset", 16'({iface_bus_grant_o, bus_dal_oe_n_o, programmed_reset_o}), 16'h6);
        $display("reset test done");
        // dma quick, slow, then racing the processor in the same cycle
        for (int k = 0; k < 3; k++)
        begin
            {dma_go, dma_beats} = {1'b1, 3'(k * 3)};
            tk(1);
            {dma_go, cpu_strobe_i, cpu_addr_i} = {1'b0, k == 2, 24'h800000};
            if (k == 2) tk(3);
            if (k == 2) chk("dma first", 16'({dma_grant_o, cpu_grant_o}), 16'h2);
            wt(dma_grant_o, 1'b1, "dma grant");
            chk("iface off", 16'(iface_bus_grant_o), 16'h0);
            wt(dma_grant_o, 1'b0, "dma release");
            wt(cpu_grant_o, 1'(k == 2), "cpu next");
            cpu_strobe_i = 1'b0;
            wt(cpu_grant_o, 1'b0, "cpu off");
            chk("iface back", 16'(iface_bus_grant_o), 16'h1);
        end
        $display("arbiter test done");
        ifc(1'b0, 16'h8200, 8'h0);
        chk("latches", 16'({programmed_reset_o, skip_self_test_o}), 16'h3);
        ifc(1'b0, 16'h0200, 8'h0);
        cpu(24'h80ff00, 1'b1, 16'h5700, 8'h0);
        chk("latches", 16'({programmed_reset_o, skip_self_test_o}), 16'h2);
        cpu(24'h80ff00, 1'b0, 16'h0, 8'h57);
        ifc(1'b1, 16'h0, 8'h47);
        $display("flag test done");
        for (int k = 0; k < 4; k++)
        begin
            {serial_int_i, iface_int_i, dma_int_i, timer_int_i} = 4'h8 >> k;
            tk(2);
            chk("level", 16'(cpu_int_level_o), 16'(lv[k]));
            {cpu_addr_i, cpu_function_code_i, valid_mem_addr_i} = {20'h0, lv[k], 1'b0, 4'hf};
            tk(2);
            chk("acks", 16'({serial_int_ack_o, iface_int_ack_o, dma_int_ack_o, timer_int_ack_o, autovector_req_o}),
                16'({4'h8 >> k, k != 0}));
            {cpu_function_code_i, valid_mem_addr_i} = 4'h0;
            wt(cpu_grant_o, 1'b0, "ack release");
        end
        {serial_int_i, iface_int_i, dma_int_i, timer_int_i} = 4'h7;
        tk(2);
        chk("level mix", 16'(cpu_int_level_o), 16'h3);
        $display("interrupt test done");
        for (int k = 0; k < 4; k++)
        begin
            {cpu_strobe_i, cpu_addr_i} = {1'b1, da[k]};
            tk(2);
            chk("select", 16'({rom_sel_o, ram_sel_o, modem_sel_o, gio_sel_o}), 16'(4'h8 >> k));
        end
        cpu_strobe_i = 1'b0;
        $display("decode test done");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
